// file: rtl/sram_burst_controller.sv
// memory controller end: link clock, command slots, beats, read buffer
`timescale 1ns/1ps
module sram_burst_controller import sram_burst_pkg::*; (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // memory pins
    sram_burst_if.controller pins,
    // link clock run control
    input wire logic run_in,
    output logic busy_out,
    // write requests
    input wire logic wr_req_valid_in,
    input wire logic [ADDR_WIDTH-1:0] wr_addr_in,
    input wire logic [BURST_WIDTH-1:0] wr_data_in,
    input wire logic [BURST_BE_WIDTH-1:0] wr_lane_enable_n_in,
    output logic wr_req_ready_out,
    // read requests
    input wire logic rd_req_valid_in,
    input wire logic [ADDR_WIDTH-1:0] rd_addr_in,
    output logic rd_req_ready_out,
    // read data return
    output logic rd_data_valid_out,
    output logic [BURST_WIDTH-1:0] rd_data_out,
    input wire logic rd_data_ready_in
);
    // link side registers and their next values
    logic mem_clk, next_mem_clk;
    slot_type slot, next_slot;
    logic rd_sel_n, next_rd_sel_n;
    logic wr_sel_n, next_wr_sel_n;
    logic [ADDR_WIDTH-1:0] addr, next_addr;
    logic [DATA_WIDTH-1:0] d, next_d;
    logic [LANES-1:0] be_n, next_be_n;
    // beat one stage ahead of the pins, so beat 0 meets the next true edge
    logic [DATA_WIDTH-1:0] d_early, next_d_early;
    logic [LANES-1:0] be_early, next_be_early;
    // write burst held for its four beats
    logic [2:0] wr_beat, next_wr_beat;
    logic [BURST_WIDTH-1:0] wr_hold, next_wr_hold;
    logic [BURST_BE_WIDTH-1:0] be_hold, next_be_hold;
    // bit i set: a read launched i+1 cycles ago
    logic [RD_TRACK_LEN-1:0] rd_track, next_rd_track;
    logic [BURST_WIDTH-DATA_WIDTH-1:0] acc, next_acc;
    // two-entry return buffer, entry 0 is the head
    logic [BUF_DEPTH-1:0] buf_valid, next_buf_valid;
    logic [BURST_WIDTH-1:0] buf_data [BUF_DEPTH];
    logic [BURST_WIDTH-1:0] next_buf_data [BUF_DEPTH];
    logic next_rd_ready, next_wr_ready, next_busy;
    // helpers
    logic pending, launch, take_rd, take_wr, push, pop, placed;
    logic [1:0] beat;
    logic [3:0] load;

    // link clock, command slots and write beats
    always_comb begin
        pending = (wr_beat != WR_BEAT_IDLE) | (|rd_track);
        // clock may stop only at low level with nothing in flight
        launch = ~mem_clk & (run_in | pending); // see RULE_11
        next_mem_clk = mem_clk ? 1'h0 : launch;
        // reads and writes take alternate true edges
        take_rd = launch & (slot == SLOT_READ) & rd_req_ready_out // see RULE_01
            & rd_req_valid_in;
        take_wr = launch & (slot == SLOT_WRITE) & wr_req_ready_out // see RULE_02
            & wr_req_valid_in;
        next_slot = launch ? slot_type'(~slot) : slot; // see RULE_08
        // select low only for the edge it belongs to
        next_rd_sel_n = ~take_rd;
        next_wr_sel_n = ~take_wr; // see RULE_12
        next_addr = take_rd ? rd_addr_in : (take_wr ? wr_addr_in : addr);
        next_wr_hold = take_wr ? wr_data_in : wr_hold;
        next_be_hold = take_wr ? wr_lane_enable_n_in : be_hold;
        // beat counter: one beat per half-period, from one cycle after command
        if (take_wr) begin
            next_wr_beat = WR_BEAT_FIRST;
        end else if (wr_beat == WR_BEAT_LAST || wr_beat == WR_BEAT_IDLE) begin
            next_wr_beat = WR_BEAT_IDLE;
        end else begin
            next_wr_beat = wr_beat + 3'h1;
        end
        beat = wr_beat[1:0] - 2'h1;
        next_d_early = d_early;
        next_be_early = LANES_OFF_N;
        // idle beats keep both lanes disabled so nothing stray is written
        if (wr_beat != WR_BEAT_IDLE) begin
            next_d_early = wr_hold[beat*DATA_WIDTH +: DATA_WIDTH]; // see RULE_07
            next_be_early = be_hold[beat*LANES +: LANES];
        end
        // second stage: beat 0 reaches the pins with the true edge after the command
        next_d = d_early; // see RULE_07
        next_be_n = be_early;
    end

    // read capture and return buffer
    always_comb begin
        next_rd_track = {rd_track[RD_TRACK_LEN-2:0], take_rd};
        // device beats stand after edges 5..8 from launch, sampled at 6..9, low beat first
        next_acc = acc;
        if (|rd_track[RD_TRACK_LEN-2:READ_LATENCY+1]) begin
            next_acc = {pins.q, acc[BURST_WIDTH-DATA_WIDTH-1:DATA_WIDTH]};
        end
        push = rd_track[RD_TRACK_LEN-1];
        pop = buf_valid[0] & rd_data_ready_in;
        // shift out the head first, then place the new burst behind
        next_buf_valid = pop ? (buf_valid >> 1) : buf_valid;
        for (int i = 0; i < BUF_DEPTH; i++) begin
            next_buf_data[i] = buf_data[i];
            if (pop && i < BUF_DEPTH - 1) begin
                next_buf_data[i] = buf_data[i+1];
            end
        end
        placed = 1'h0;
        for (int i = 0; i < BUF_DEPTH; i++) begin
            if (push && !placed && !next_buf_valid[i]) begin
                next_buf_data[i] = {pins.q, acc};
                next_buf_valid[i] = 1'h1;
                placed = 1'h1;
            end
        end
        // credit: buffered plus in-flight bursts must leave a free entry;
        // this is what lets a stalled reader hold off new reads losslessly
        load = 4'h0;
        for (int i = 0; i < BUF_DEPTH; i++) begin
            load = load + 4'(buf_valid[i]);
        end
        for (int i = 0; i < RD_TRACK_LEN; i++) begin
            load = load + 4'(rd_track[i]);
        end
        // ready is registered here, so it is offered only in the cycle of the matching launch
        next_rd_ready = mem_clk & (slot == SLOT_READ) & run_in
            & (load < 4'(BUF_DEPTH));
        next_wr_ready = mem_clk & (slot == SLOT_WRITE) & run_in;
        next_busy = (next_wr_beat != WR_BEAT_IDLE) | (|next_rd_track);
    end

    // register everything but the buffer data
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mem_clk <= 1'h0;
            slot <= SLOT_READ;
            rd_sel_n <= SELECT_IDLE_N;
            wr_sel_n <= SELECT_IDLE_N;
            addr <= '0;
            d <= '0;
            be_n <= LANES_OFF_N;
            d_early <= '0;
            be_early <= LANES_OFF_N;
            wr_beat <= WR_BEAT_IDLE;
            wr_hold <= '0;
            be_hold <= '1;
            rd_track <= '0;
            acc <= '0;
            buf_valid <= '0;
            rd_req_ready_out <= 1'h0;
            wr_req_ready_out <= 1'h0;
            busy_out <= 1'h0;
        end else begin
            mem_clk <= next_mem_clk;
            slot <= next_slot;
            rd_sel_n <= next_rd_sel_n;
            wr_sel_n <= next_wr_sel_n;
            addr <= next_addr;
            d <= next_d;
            be_n <= next_be_n;
            d_early <= next_d_early;
            be_early <= next_be_early;
            wr_beat <= next_wr_beat;
            wr_hold <= next_wr_hold;
            be_hold <= next_be_hold;
            rd_track <= next_rd_track;
            acc <= next_acc;
            buf_valid <= next_buf_valid;
            rd_req_ready_out <= next_rd_ready;
            wr_req_ready_out <= next_wr_ready;
            busy_out <= next_busy;
        end
    end

    // buffer data needs no reset, valid bits qualify it
    always_ff @(posedge clk_in) begin
        buf_data <= next_buf_data;
    end

    // outputs straight from flops
    assign rd_data_valid_out = buf_valid[0];
    assign rd_data_out = buf_data[0];
    assign pins.mem_clk = mem_clk;
    assign pins.read_select_n = rd_sel_n;
    assign pins.write_select_n = wr_sel_n;
    assign pins.addr = addr;
    assign pins.d = d;
    assign pins.lane0_write_enable_n = be_n[0];
    assign pins.lane1_write_enable_n = be_n[1];
endmodule : sram_burst_controller

// file: rtl/sram_burst_device.sv
// sram device end: command decode, burst pipelines and storage
//
// Function
// RULE_01: controller issues read, then write next cycle
// RULE_02: write command sits one cycle after read
// RULE_03: read select low on true edge starts read
// RULE_04: write select low on true edge starts write
// RULE_05: every burst is four beats, self-addressed
// RULE_06: read beats driven 2.0 to 3.5 cycles later
// RULE_07: controller supplies write beats on both phases
// RULE_08: same-type commands at most every second edge
// RULE_09: back-to-back same-type command is ignored
// RULE_10: both selects low after idle: read wins
// RULE_11: clock stops only after bursts complete
// RULE_12: write select low at the write edge
// RULE_13: each lane written only when enable low
// RULE_14: both selects high starts nothing
// RULE_15: stopped clock freezes all device state
`timescale 1ns/1ps
module sram_burst_device import sram_burst_pkg::*; (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // memory pins
    sram_burst_if.device pins,
    // command observation
    output logic read_start_out,
    output logic write_start_out
);
    // link clock level one system cycle ago
    logic clk_prev;
    logic next_clk_prev;
    // any link edge, and the true rising edge
    logic tick;
    logic true_edge;
    // what the previous true edge did
    logic rd_prev;
    logic wr_prev;
    logic nop_prev;
    logic next_rd_prev;
    logic next_wr_prev;
    logic next_nop_prev;
    // command acceptance on this edge
    logic accept_rd;
    logic accept_wr;
    // read pipeline, one stage per half-period
    logic [RD_STAGES-1:0] rd_valid;
    logic [RD_STAGES-1:0] next_rd_valid;
    logic [ADDR_WIDTH-1:0] rd_addr [RD_STAGES];
    logic [ADDR_WIDTH-1:0] next_rd_addr [RD_STAGES];
    // write pipeline, one stage per half-period
    logic [WR_STAGES-1:0] wr_valid;
    logic [WR_STAGES-1:0] next_wr_valid;
    logic [ADDR_WIDTH-1:0] wr_addr [WR_STAGES];
    logic [ADDR_WIDTH-1:0] next_wr_addr [WR_STAGES];
    // beat currently due on each port
    logic rd_hit;
    logic wr_hit;
    logic [WORD_ADDR_WIDTH-1:0] rd_word;
    logic [WORD_ADDR_WIDTH-1:0] wr_word;
    // output drive and status flops
    logic q_oe;
    logic next_q_oe;
    logic next_read_start;
    logic next_write_start;
    // lane enables as a vector
    logic [LANES-1:0] lane_en_n;
    logic [DATA_WIDTH-1:0] q_word;

    assign lane_en_n = {pins.lane1_write_enable_n, pins.lane0_write_enable_n};

    // edge detection: the link clock is a plain level from same-clock logic
    always_comb begin
        tick = pins.mem_clk != clk_prev;
        true_edge = pins.mem_clk & ~clk_prev;
        next_clk_prev = pins.mem_clk;
    end

    // command decode and pipeline advance
    always_comb begin
        // a repeated read on the next edge is dropped
        accept_rd = true_edge & ~pins.read_select_n & ~rd_prev; // see RULE_03 see RULE_09
        // write also dropped when a read wins after an idle edge
        accept_wr = true_edge & ~pins.write_select_n & ~wr_prev // see RULE_04 see RULE_09
            & ~(~pins.read_select_n & nop_prev); // see RULE_10
        next_rd_prev = rd_prev;
        next_wr_prev = wr_prev;
        next_nop_prev = nop_prev;
        if (true_edge) begin
            next_rd_prev = accept_rd;
            next_wr_prev = accept_wr;
            // both selects high: nothing starts, output stays off unless busy
            next_nop_prev = pins.read_select_n & pins.write_select_n; // see RULE_14
        end
        // no link edge means nothing moves, so a stopped clock freezes us
        next_rd_valid = rd_valid; // see RULE_15
        next_wr_valid = wr_valid;
        next_rd_addr = rd_addr;
        next_wr_addr = wr_addr;
        if (tick) begin
            next_rd_valid = {rd_valid[RD_STAGES-2:0], accept_rd};
            next_wr_valid = {wr_valid[WR_STAGES-2:0], accept_wr};
            next_rd_addr[0] = pins.addr;
            next_wr_addr[0] = pins.addr;
            for (int i = 1; i < RD_STAGES; i++) begin
                next_rd_addr[i] = rd_addr[i-1];
            end
            for (int i = 1; i < WR_STAGES; i++) begin
                next_wr_addr[i] = wr_addr[i-1];
            end
        end
    end

    // pick the beat due now; spacing of two cycles keeps it unique
    always_comb begin
        rd_hit = 1'h0;
        wr_hit = 1'h0;
        rd_word = '0;
        wr_word = '0;
        // read beats leave on half-periods 4..7 after the command
        for (int b = 0; b < BURST_LEN; b++) begin
            if (rd_valid[READ_LATENCY-1+b]) begin // see RULE_06
                rd_hit = 1'h1;
                // burst counter runs linearly from the given address
                rd_word = {rd_addr[READ_LATENCY-1+b], BEAT_WIDTH'(b)}; // see RULE_05
            end
        end
        // write beats arrive on half-periods 2..5 after the command
        for (int b = 0; b < BURST_LEN; b++) begin
            if (wr_valid[WRITE_LATENCY-1+b]) begin
                wr_hit = 1'h1;
                wr_word = {wr_addr[WRITE_LATENCY-1+b], BEAT_WIDTH'(b)}; // see RULE_05
            end
        end
        // drive only during a burst; hold when the clock stands still
        next_q_oe = tick ? rd_hit : q_oe; // see RULE_14 see RULE_15
        next_read_start = accept_rd;
        next_write_start = accept_wr;
    end

    // register control state
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            clk_prev <= 1'h0;
            rd_prev <= 1'h0;
            wr_prev <= 1'h0;
            nop_prev <= 1'h1;
            rd_valid <= '0;
            wr_valid <= '0;
            q_oe <= 1'h0;
            read_start_out <= 1'h0;
            write_start_out <= 1'h0;
        end else begin
            clk_prev <= next_clk_prev;
            rd_prev <= next_rd_prev;
            wr_prev <= next_wr_prev;
            nop_prev <= next_nop_prev;
            rd_valid <= next_rd_valid;
            wr_valid <= next_wr_valid;
            q_oe <= next_q_oe;
            read_start_out <= next_read_start;
            write_start_out <= next_write_start;
        end
    end

    // addresses carry no reset: they are qualified by the valid bits
    always_ff @(posedge clk_in) begin
        rd_addr <= next_rd_addr;
        wr_addr <= next_wr_addr;
    end

    // per-lane storage; each lane has its own array so byte writes are free
    generate
        for (genvar g = 0; g < LANES; g++) begin : lane
            logic [LANE_WIDTH-1:0] mem [MEM_DEPTH];
            logic [LANE_WIDTH-1:0] q_lane;
            // write only when this lane's enable was low with the beat
            always_ff @(posedge clk_in) begin
                if (tick && wr_hit && !lane_en_n[g]) begin // see RULE_13
                    mem[wr_word] <= pins.d[g*LANE_WIDTH +: LANE_WIDTH];
                end
            end
            // read beat register; frozen while the clock stands still
            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    q_lane <= '0;
                end else if (tick && rd_hit) begin // see RULE_06 see RULE_15
                    q_lane <= mem[rd_word];
                end
            end
            assign q_word[g*LANE_WIDTH +: LANE_WIDTH] = q_lane;
        end
    endgenerate

    // pin outputs straight from the flops above
    assign pins.q = q_word;
    assign pins.q_oe = q_oe;
endmodule : sram_burst_device

// file: rtl/sram_burst_if.sv
// pins between the memory controller and the sram
`timescale 1ns/1ps
interface sram_burst_if import sram_burst_pkg::*; ();
    logic mem_clk;                          // true link clock, made by controller
    logic read_select_n;                    // read command, low active
    logic write_select_n;                   // write command, low active
    logic [ADDR_WIDTH-1:0] addr;            // burst start address
    logic [DATA_WIDTH-1:0] d;               // write data beat
    logic lane0_write_enable_n;             // lane 0 write enable
    logic lane1_write_enable_n;             // lane 1 write enable
    logic [DATA_WIDTH-1:0] q;               // read data beat
    logic q_oe;                             // read data driven
    modport device (
        input mem_clk, read_select_n, write_select_n, addr, d,
        input lane0_write_enable_n, lane1_write_enable_n,
        output q, q_oe
    );
    modport controller (
        output mem_clk, read_select_n, write_select_n, addr, d,
        output lane0_write_enable_n, lane1_write_enable_n,
        input q, q_oe
    );
endinterface : sram_burst_if

// file: rtl/sram_burst_pkg.sv
// shared constants and types for the burst-of-four sram link
package sram_burst_pkg;
    // geometry of the 18-bit organisation
    localparam int ADDR_WIDTH = 18;
    localparam int DATA_WIDTH = 18;
    localparam int LANE_WIDTH = 9;
    localparam int LANES = 2;
    localparam int BURST_LEN = 4;
    localparam int BEAT_WIDTH = 2;
    localparam int WORD_ADDR_WIDTH = ADDR_WIDTH + BEAT_WIDTH;
    localparam int MEM_DEPTH = 1 << WORD_ADDR_WIDTH;
    localparam int BURST_WIDTH = DATA_WIDTH * BURST_LEN;
    localparam int BURST_BE_WIDTH = LANES * BURST_LEN;
    // half-periods of the link clock from command edge to first beat
    localparam int READ_LATENCY = 4;
    localparam int WRITE_LATENCY = 2;
    // depth of the device command pipelines, in half-periods
    localparam int RD_STAGES = READ_LATENCY + BURST_LEN - 1;
    localparam int WR_STAGES = WRITE_LATENCY + BURST_LEN - 1;
    // controller read tracking and return buffer
    // one extra stage: a beat is only sampled the edge after the device drives it
    localparam int RD_TRACK_LEN = READ_LATENCY + BURST_LEN + 1;
    localparam int BUF_DEPTH = 2;
    localparam logic [2:0] WR_BEAT_IDLE = 3'h0;
    localparam logic [2:0] WR_BEAT_FIRST = 3'h1;
    localparam logic [2:0] WR_BEAT_LAST = 3'h4;
    // values after reset
    localparam logic SELECT_IDLE_N = 1'h1;
    localparam logic [LANES-1:0] LANES_OFF_N = 2'h3;
    // command slot: reads and writes alternate on true edges
    typedef enum logic {SLOT_READ = 1'h0, SLOT_WRITE = 1'h1} slot_type;
endpackage : sram_burst_pkg

// file: tb/sram_burst_properties.sv
// concurrent checks on the link between controller and sram device
`timescale 1ns/1ps
module sram_burst_properties import sram_burst_pkg::*; (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // link signals under watch
    input wire logic mem_clk,
    input wire logic read_select_n,
    input wire logic write_select_n,
    input wire logic lane0_write_enable_n,
    input wire logic lane1_write_enable_n,
    input wire logic [DATA_WIDTH-1:0] q,
    input wire logic q_oe
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // commands only count on a rising link clock
    sequence true_edge;
        mem_clk && !$past(mem_clk);
    endsequence
    sequence read_cmd;
        !read_select_n;
    endsequence
    // one full burst on the read port
    sequence four_beats;
        q_oe [*4];
    endsequence
    a_read_edge: assert property (read_cmd |-> true_edge)
        else $error("read select low off a true edge");
    a_write_edge: assert property (!write_select_n |-> true_edge)
        else $error("write select low off a true edge");
    a_slot_alternate: assert property (read_cmd |-> write_select_n)
        else $error("read and write share one slot");
    a_read_gap: assert property (read_cmd |=> read_select_n [*3])
        else $error("reads closer than two link cycles");
    a_write_gap: assert property (!write_select_n |=> write_select_n [*3])
        else $error("writes closer than two link cycles");
    a_read_beats: assert property (read_cmd |-> ##5 four_beats)
        else $error("read beats missing after command");
    a_read_end: assert property (read_cmd ##4 read_select_n |-> ##5 !q_oe)
        else $error("read port still driven after four beats");
    // a frozen link clock must freeze the read port too
    a_frozen_hold: assert property ($stable(mem_clk) |=> $stable(q) && $stable(q_oe))
        else $error("read port moved with clock stopped");
    a_stop_idle: assert property ($stable(mem_clk) ##1 $stable(mem_clk)
        |-> !q_oe && lane0_write_enable_n && lane1_write_enable_n)
        else $error("clock stopped with a burst pending");
endmodule : sram_burst_properties

// file: tb/tb_quad_burst4_sram_port_timing.sv
// bench joining controller and device, plus a rule-breaking driver on a spare device
`timescale 1ns/1ps
module tb_quad_burst4_sram_port_timing import sram_burst_pkg::*;;
    // one write/read case: address, burst data, lane enables
    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;
        logic [BURST_WIDTH-1:0] data;
        logic [BURST_BE_WIDTH-1:0] lanes_n;
    } row_type;
    localparam logic [BURST_WIDTH-1:0] BG = 72'hA5A5A5A5A5A5A5A5A5; // background fill
    logic clk_in = 1'h0;
    logic reset_in = 1'h1;
    logic run = 1'h1;
    logic wr_valid = 1'h0;
    logic [ADDR_WIDTH-1:0] wr_addr = '0;
    logic [BURST_WIDTH-1:0] wr_data = '0;
    logic [BURST_BE_WIDTH-1:0] wr_en_n = 8'hFF;
    logic rd_valid = 1'h0;
    logic [ADDR_WIDTH-1:0] rd_addr = '0;
    logic rd_ready = 1'h0;
    logic busy, wr_ready, rd_req_ready, rd_valid_out, rs, ws, rs2, ws2;
    logic [BURST_WIDTH-1:0] rd_data;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int nr = 0;
    int nw = 0;
    int i;
    row_type rows [4];
    sram_burst_if link();
    sram_burst_if fault_link(); // driven by the bench, breaks the command rules
    sram_burst_controller sram_burst_controller_i (.clk_in(clk_in), .reset_in(reset_in),
        .pins(link), .run_in(run), .busy_out(busy), .wr_req_valid_in(wr_valid),
        .wr_addr_in(wr_addr), .wr_data_in(wr_data), .wr_lane_enable_n_in(wr_en_n),
        .wr_req_ready_out(wr_ready), .rd_req_valid_in(rd_valid), .rd_addr_in(rd_addr),
        .rd_req_ready_out(rd_req_ready), .rd_data_valid_out(rd_valid_out),
        .rd_data_out(rd_data), .rd_data_ready_in(rd_ready));
    sram_burst_device sram_burst_device_i (.clk_in(clk_in), .reset_in(reset_in),
        .pins(link), .read_start_out(rs), .write_start_out(ws));
    sram_burst_device sram_burst_device_i2 (.clk_in(clk_in), .reset_in(reset_in),
        .pins(fault_link), .read_start_out(rs2), .write_start_out(ws2));
    sram_burst_properties sram_burst_properties_i (.clk_in(clk_in), .reset_in(reset_in),
        .mem_clk(link.mem_clk), .read_select_n(link.read_select_n),
        .write_select_n(link.write_select_n), .lane0_write_enable_n(link.lane0_write_enable_n),
        .lane1_write_enable_n(link.lane1_write_enable_n), .q(link.q), .q_oe(link.q_oe));
    always #4 clk_in = ~clk_in;
    // hang guard and pulse counters of the spare device
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (rs2 === 1'h1) nr <= nr + 1;
        if (ws2 === 1'h1) nw <= nw + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            print_verdict();
        end
    end
    task automatic check(input logic [BURST_WIDTH-1:0] seen, input logic [BURST_WIDTH-1:0] exp,
                         input string msg);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask : check
    task print_verdict;
        if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    // lanes left disabled keep the background fill
    function automatic logic [BURST_WIDTH-1:0] merge(input row_type r);
        logic [BURST_WIDTH-1:0] m;
        m = BG;
        for (int b = 0; b < BURST_LEN * LANES; b++)
            if (!r.lanes_n[b]) m[b*LANE_WIDTH +: LANE_WIDTH] = r.data[b*LANE_WIDTH +: LANE_WIDTH];
        return m;
    endfunction : merge
    // request held until the ready pulse is sampled on an edge
    task automatic do_write(input row_type r);
        int k;
        @(posedge clk_in); #1;
        wr_valid = 1'h1;
        wr_addr = r.addr;
        wr_data = r.data;
        wr_en_n = r.lanes_n;
        for (k = 0; k < 40 && wr_ready !== 1'h1; k++) begin
            @(posedge clk_in); #1;
        end
        check(wr_ready, 1'h1, "write request not taken");
        @(posedge clk_in); #1;
        wr_valid = 1'h0;
    endtask : do_write
    task automatic do_read(input logic [ADDR_WIDTH-1:0] a);
        int k;
        @(posedge clk_in); #1;
        rd_valid = 1'h1;
        rd_addr = a;
        for (k = 0; k < 40 && rd_req_ready !== 1'h1; k++) begin
            @(posedge clk_in); #1;
        end
        check(rd_req_ready, 1'h1, "read request not taken");
        @(posedge clk_in); #1;
        rd_valid = 1'h0;
    endtask : do_read
    // lat above zero also checks cycles from the taking edge to valid
    task automatic pop(input logic [BURST_WIDTH-1:0] exp, input int lat);
        int n;
        @(posedge clk_in); #1;
        for (n = 1; n < 40 && rd_valid_out !== 1'h1; n++) begin
            @(posedge clk_in); #1;
        end
        if (lat > 0) check(n, lat, "read return latency");
        check(rd_data, exp, "read burst data");
        rd_ready = 1'h1;
        @(posedge clk_in); #1;
        rd_ready = 1'h0;
    endtask : pop
    // one link cycle on the spare device, selects low only in the high half
    task automatic link_cycle(input logic r_n, input logic w_n);
        @(posedge clk_in); #1;
        fault_link.mem_clk = 1'h1;
        fault_link.read_select_n = r_n;
        fault_link.write_select_n = w_n;
        fault_link.d = ~fault_link.d;
        @(posedge clk_in); #1;
        fault_link.mem_clk = 1'h0;
        fault_link.read_select_n = 1'h1;
        fault_link.write_select_n = 1'h1;
        fault_link.d = ~fault_link.d;
    endtask : link_cycle
    initial begin
        fault_link.mem_clk = 1'h0;
        fault_link.read_select_n = 1'h1;
        fault_link.write_select_n = 1'h1;
        fault_link.addr = 18'h00010;
        fault_link.d = 18'h0AAAA;
        fault_link.lane0_write_enable_n = 1'h1; // aborted writes leave memory alone
        fault_link.lane1_write_enable_n = 1'h1;
        rows[0] = '{18'h00000, 72'h0123456789ABCDEF01, 8'h00};
        rows[1] = '{18'h3FFFF, 72'hFEDCBA987654321012, 8'hAA};
        rows[2] = '{18'h15555, 72'h3C3C3C3C3C3C3C3C3C, 8'h55};
        rows[3] = '{18'h00004, 72'h5A5A5A5A5A5A5A5A5A, 8'h9C};
        repeat (2) @(posedge clk_in);
        #1;
        // idle link while reset is held
        check(link.mem_clk, 1'h0, "link clock not idle");
        check({link.read_select_n, link.write_select_n}, 2'h3, "selects not idle");
        check(link.q_oe, 1'h0, "read port driven in reset");
        reset_in = 1'h0;
        // fill, write with the row's lane enables, read back for each row
        for (i = 0; i < 4; i++) begin
            do_write('{rows[i].addr, BG, 8'h00});
            do_write(rows[i]);
            do_read(rows[i].addr);
            pop(merge(rows[i]), 9);
        end
        // stalled receiver: two bursts buffered, a third is refused
        do_read(rows[0].addr);
        do_read(rows[1].addr);
        @(posedge clk_in); #1;
        rd_valid = 1'h1;
        rd_addr = rows[2].addr;
        for (i = 0; i < 40 && rd_req_ready !== 1'h1; i++) begin
            @(posedge clk_in); #1;
        end
        check(i, 40, "read taken with buffer full");
        rd_valid = 1'h0;
        pop(merge(rows[0]), 0);
        pop(merge(rows[1]), 0);
        // stop the link clock, then restart it
        run = 1'h0;
        for (i = 0; i < 40 && busy !== 1'h0; i++) begin
            @(posedge clk_in); #1;
        end
        repeat (4) @(posedge clk_in);
        #1;
        check({link.mem_clk, wr_ready, rd_req_ready}, 3'h0, "link not stopped");
        repeat (8) @(posedge clk_in);
        #1;
        check({link.mem_clk, link.q_oe}, 2'h0, "link moved while stopped");
        run = 1'h1;
        do_read(rows[2].addr);
        pop(merge(rows[2]), 0);
        // spare device: back-to-back reads, both selects low after a nop, back-to-back writes
        link_cycle(1'h0, 1'h1);
        link_cycle(1'h0, 1'h1);
        repeat (6) link_cycle(1'h1, 1'h1);
        check(nr, 1, "repeated read not ignored");
        link_cycle(1'h0, 1'h0);
        repeat (6) link_cycle(1'h1, 1'h1);
        check({nr[1:0], nw[1:0]}, 4'h8, "write not dropped after nop");
        link_cycle(1'h1, 1'h0);
        link_cycle(1'h1, 1'h0);
        repeat (4) link_cycle(1'h1, 1'h1);
        check(nw, 1, "repeated write not ignored");
        print_verdict();
    end
endmodule : tb_quad_burst4_sram_port_timing
